// ==== core/special_reg_file.v ====
// Architected register set: general registers, operand selection for the
// execution units, and the special register move decode with privilege and
// undefined-number handling.
// Assumes the execution units present one request at a time, all in the
// ref_clk domain, so no input needs synchronising.
//
// Function
// [RL1] Compute operands come only from registers or the immediate.
// [RL2] Two source reads and a separate destination; sources stay unchanged.
// [RL3] Memory requests issue only for load and store instruction classes.
// [RL4] User access to a supervisor register is suppressed and trapped.
// [RL5] Undefined number with encoding msb set raises a program exception.
// [RL6] Undefined special number with encoding msb clear completes as no-op.
// [RL7] Address-sized registers follow the implementation width parameter.
// [RL8] Special registers selected by number; carry/overflow status is 1.
// [RL9] Reserved special register bits read zero and ignore writes.
// [RL10] Time base read through read numbers, written only by supervisor.
`timescale 1ns/10ps
`include "special_reg_consts.vh"

module special_reg_file #(
   parameter        XLEN       = 32,
   // Arbitrary neutral identification value.
   parameter [31:0] VERSION_ID = 32'h00010001
) (
   input  wire            ref_clk,
   input  wire            rst_n,
   input  wire            ex_valid,
   input  wire            ex_compute,
   input  wire            ex_mem,
   input  wire [4:0]      ex_ra,
   input  wire [4:0]      ex_rb,
   input  wire            ex_use_imm,
   input  wire [15:0]     ex_imm,
   input  wire            dest_we,
   input  wire [4:0]      dest_waddr,
   input  wire [XLEN-1:0] dest_wdata,
   input  wire            msw_we,
   input  wire [XLEN-1:0] msw_wdata,
   input  wire            move_valid,
   input  wire            move_write,
   input  wire [9:0]      move_num,
   input  wire [XLEN-1:0] move_wdata,
   output reg             op_valid,
   output reg  [XLEN-1:0] op_a,
   output reg  [XLEN-1:0] op_b,
   output reg             mem_req,
   output reg             move_done,
   output reg  [XLEN-1:0] move_rdata,
   output reg             priv_exc,
   output reg             prog_exc,
   output reg             user_mode
);

   ////////////////////////////////////////////////////////////////////////
   // Storage.

   reg [XLEN-1:0] general_reg [0:31];
   reg [XLEN-1:0] machine_state_word_reg;
   reg [31:0]     integer_carry_overflow_status_reg;
   reg [XLEN-1:0] branch_return_target_reg;
   reg [XLEN-1:0] loop_count_reg;
   reg [31:0]     data_fault_cause_reg;
   reg [XLEN-1:0] data_fault_address_reg;
   reg [31:0]     countdown_timer_reg;
   reg [XLEN-1:0] page_table_base_reg;
   reg [XLEN-1:0] save_restore_pc_reg;
   reg [XLEN-1:0] save_restore_state_reg;
   reg [XLEN-1:0] scratch_special_reg [0:3];
   reg [31:0]     external_access_control_reg;
   reg [31:0]     time_base_lower_reg;
   reg [31:0]     time_base_upper_reg;
   reg [31:0]     block_translation_upper_reg;
   reg [31:0]     block_translation_lower_reg;
   reg [XLEN-1:0] data_breakpoint_address_reg;

   ////////////////////////////////////////////////////////////////////////
   // Decode functions.

   function is_scratch;
      input [9:0] n;
      begin
         is_scratch = ({n[9:2], 2'b00} == `NUM_SCRATCH_SPECIAL_FIRST);
      end
   endfunction

   // A number is defined only in the direction it supports.
   function num_defined;
      input [9:0] n;
      input       w;
      begin
         case (n)
            `NUM_INTEGER_CARRY_OVERFLOW_STATUS,
            `NUM_BRANCH_RETURN_TARGET,
            `NUM_LOOP_COUNT,
            `NUM_DATA_FAULT_CAUSE,
            `NUM_DATA_FAULT_ADDRESS,
            `NUM_COUNTDOWN_TIMER,
            `NUM_PAGE_TABLE_BASE,
            `NUM_SAVE_RESTORE_PC,
            `NUM_SAVE_RESTORE_STATE,
            `NUM_EXTERNAL_ACCESS_CONTROL,
            `NUM_BLOCK_TRANSLATION_UPPER,
            `NUM_BLOCK_TRANSLATION_LOWER,
            `NUM_DATA_BREAKPOINT_ADDRESS: num_defined = 1'b1;
            `NUM_TIME_BASE_LOWER_READ,
            `NUM_TIME_BASE_UPPER_READ,
            `NUM_PROCESSOR_VERSION_ID:    num_defined = ~w;
            `NUM_TIME_BASE_LOWER_WRITE,
            `NUM_TIME_BASE_UPPER_WRITE:   num_defined = w;
            default:                      num_defined = is_scratch(n);
         endcase
      end
   endfunction

   function num_supervisor;
      input [9:0] n;
      begin
         case (n)
            `NUM_INTEGER_CARRY_OVERFLOW_STATUS,
            `NUM_BRANCH_RETURN_TARGET,
            `NUM_LOOP_COUNT,
            `NUM_TIME_BASE_LOWER_READ,
            `NUM_TIME_BASE_UPPER_READ: num_supervisor = 1'b0;
            default:                   num_supervisor = 1'b1;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Special register access classification.

   wire move_known = num_defined(move_num, move_write);
   // The instruction field swaps the two five-bit halves of the number, so
   // the encoding's most significant bit is bit 4 of the plain number.
   wire move_enc_msb = move_num[4];
   wire move_denied = move_known & num_supervisor(move_num) &
                      machine_state_word_reg[`MSW_USER_LEVEL_BIT];
   wire move_take = move_valid & move_known & ~move_denied;
   wire move_do_write = move_take & move_write;

   // Read data selection.
   // [RL8] select by number
   reg [XLEN-1:0] move_rdata_next;
   always @* begin
      move_rdata_next = {XLEN{1'b0}};
      case (move_num)
         `NUM_INTEGER_CARRY_OVERFLOW_STATUS:
            move_rdata_next[31:0] = integer_carry_overflow_status_reg;
         `NUM_BRANCH_RETURN_TARGET:
            move_rdata_next = branch_return_target_reg;
         `NUM_LOOP_COUNT:
            move_rdata_next = loop_count_reg;
         `NUM_DATA_FAULT_CAUSE:
            move_rdata_next[31:0] = data_fault_cause_reg;
         `NUM_DATA_FAULT_ADDRESS:
            move_rdata_next = data_fault_address_reg;
         `NUM_COUNTDOWN_TIMER:
            move_rdata_next[31:0] = countdown_timer_reg;
         `NUM_PAGE_TABLE_BASE:
            move_rdata_next = page_table_base_reg;
         `NUM_SAVE_RESTORE_PC:
            move_rdata_next = save_restore_pc_reg;
         `NUM_SAVE_RESTORE_STATE:
            move_rdata_next = save_restore_state_reg;
         // [RL10] time base reads
         `NUM_TIME_BASE_LOWER_READ:
            move_rdata_next[31:0] = time_base_lower_reg;
         `NUM_TIME_BASE_UPPER_READ:
            move_rdata_next[31:0] = time_base_upper_reg;
         `NUM_EXTERNAL_ACCESS_CONTROL:
            move_rdata_next[31:0] = external_access_control_reg;
         `NUM_PROCESSOR_VERSION_ID:
            move_rdata_next[31:0] = VERSION_ID;
         `NUM_BLOCK_TRANSLATION_UPPER:
            move_rdata_next[31:0] = block_translation_upper_reg;
         `NUM_BLOCK_TRANSLATION_LOWER:
            move_rdata_next[31:0] = block_translation_lower_reg;
         `NUM_DATA_BREAKPOINT_ADDRESS:
            move_rdata_next = data_breakpoint_address_reg;
         default: begin
            if (is_scratch(move_num)) begin
               move_rdata_next = scratch_special_reg[move_num[1:0]];
            end
         end
      endcase
      if (!move_take || move_write) begin
         move_rdata_next = {XLEN{1'b0}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Special register outcome and state.

   integer i;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         move_done  <= 1'b0;
         priv_exc   <= 1'b0;
         prog_exc   <= 1'b0;
         move_rdata <= {XLEN{1'b0}};
         user_mode <= 1'b0;
         machine_state_word_reg            <= {XLEN{1'b0}};
         integer_carry_overflow_status_reg <= `RESET_WORD32;
         branch_return_target_reg          <= {XLEN{1'b0}};
         loop_count_reg                    <= {XLEN{1'b0}};
         data_fault_cause_reg              <= `RESET_WORD32;
         data_fault_address_reg            <= {XLEN{1'b0}};
         countdown_timer_reg               <= `RESET_WORD32;
         page_table_base_reg               <= {XLEN{1'b0}};
         save_restore_pc_reg               <= {XLEN{1'b0}};
         save_restore_state_reg            <= {XLEN{1'b0}};
         external_access_control_reg       <= `RESET_WORD32;
         time_base_lower_reg               <= `RESET_WORD32;
         time_base_upper_reg               <= `RESET_WORD32;
         block_translation_upper_reg       <= `RESET_WORD32;
         block_translation_lower_reg       <= `RESET_WORD32;
         data_breakpoint_address_reg       <= {XLEN{1'b0}};
         for (i = 0; i < 4; i = i + 1) begin
            scratch_special_reg[i] <= {XLEN{1'b0}};
         end
      end else begin
         // [RL6] undefined no-op
         move_done  <= move_valid &
                       (move_take | (~move_known & ~move_enc_msb));
         // [RL4] privilege suppression
         priv_exc   <= move_valid & move_denied;
         // [RL5] undefined program exception
         prog_exc   <= move_valid & ~move_known & move_enc_msb;
         move_rdata <= move_rdata_next;
         user_mode <= msw_we ? msw_wdata[`MSW_USER_LEVEL_BIT] :
                      machine_state_word_reg[`MSW_USER_LEVEL_BIT];
         if (msw_we) begin
            machine_state_word_reg <= msw_wdata;
         end
         if (move_do_write) begin
            case (move_num)
               // [RL9] reserved bits masked
               `NUM_INTEGER_CARRY_OVERFLOW_STATUS:
                  integer_carry_overflow_status_reg <=
                     move_wdata[31:0] & `MASK_INTEGER_CARRY_OVERFLOW;
               `NUM_BRANCH_RETURN_TARGET:
                  branch_return_target_reg <= move_wdata;
               `NUM_LOOP_COUNT:
                  loop_count_reg <= move_wdata;
               `NUM_DATA_FAULT_CAUSE:
                  data_fault_cause_reg <= move_wdata[31:0];
               `NUM_DATA_FAULT_ADDRESS:
                  data_fault_address_reg <= move_wdata;
               `NUM_COUNTDOWN_TIMER:
                  countdown_timer_reg <= move_wdata[31:0];
               `NUM_PAGE_TABLE_BASE:
                  page_table_base_reg <= move_wdata;
               `NUM_SAVE_RESTORE_PC:
                  save_restore_pc_reg <= move_wdata;
               `NUM_SAVE_RESTORE_STATE:
                  save_restore_state_reg <= move_wdata;
               `NUM_EXTERNAL_ACCESS_CONTROL:
                  external_access_control_reg <=
                     move_wdata[31:0] & `MASK_EXTERNAL_ACCESS;
               // [RL10] supervisor time base write
               `NUM_TIME_BASE_LOWER_WRITE:
                  time_base_lower_reg <= move_wdata[31:0];
               `NUM_TIME_BASE_UPPER_WRITE:
                  time_base_upper_reg <= move_wdata[31:0];
               `NUM_BLOCK_TRANSLATION_UPPER:
                  block_translation_upper_reg <=
                     move_wdata[31:0] & `MASK_BLOCK_TRANSLATION_UP;
               `NUM_BLOCK_TRANSLATION_LOWER:
                  block_translation_lower_reg <=
                     move_wdata[31:0] & `MASK_BLOCK_TRANSLATION_LO;
               `NUM_DATA_BREAKPOINT_ADDRESS:
                  data_breakpoint_address_reg <= move_wdata;
               default: begin
                  if (is_scratch(move_num)) begin
                     scratch_special_reg[move_num[1:0]] <= move_wdata;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // General registers and operand delivery.

   // [RL7] width follows implementation
   always @(posedge ref_clk) begin
      if (dest_we) begin
         general_reg[dest_waddr] <= dest_wdata;
      end
   end

   // Sources are read before a same-cycle destination write lands, so a
   // write to a source register never alters the operands of this request.
   // [RL1] register or immediate operands
   // [RL2] independent destination
   wire [XLEN-1:0] imm_ext = {{(XLEN-16){ex_imm[15]}}, ex_imm};
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_valid <= 1'b0;
         op_a     <= {XLEN{1'b0}};
         op_b     <= {XLEN{1'b0}};
         mem_req  <= 1'b0;
      end else begin
         op_valid <= ex_valid & (ex_compute | ex_mem);
         // [RL3] memory only for load/store
         mem_req  <= ex_valid & ex_mem & ~ex_compute;
         if (ex_valid) begin
            op_a <= general_reg[ex_ra];
            op_b <= ex_use_imm ? imm_ext : general_reg[ex_rb];
         end
      end
   end

endmodule

// ==== dv/exec_unit_model.sv ====
// Execution unit model: issues operand, state and special move requests.
// Assumes the core samples on rising ref_clk; this drives on falling.
`timescale 1ns/10ps
module exec_unit_model #(
   parameter XLEN = 32
) (
   input  wire logic            ref_clk,
   output logic                 ex_valid,
   output logic                 ex_compute,
   output logic                 ex_mem,
   output logic                 ex_use_imm,
   output logic [4:0]           ex_ra,
   output logic [4:0]           ex_rb,
   output logic [4:0]           dest_waddr,
   output logic [15:0]          ex_imm,
   output logic                 dest_we,
   output logic                 msw_we,
   output logic                 move_valid,
   output logic                 move_write,
   output logic [XLEN-1:0]      dest_wdata,
   output logic [XLEN-1:0]      msw_wdata,
   output logic [XLEN-1:0]      move_wdata,
   output logic [9:0]           move_num,
   input  wire logic            move_done,
   input  wire logic            priv_exc,
   input  wire logic            prog_exc,
   input  wire logic [XLEN-1:0] move_rdata
);
   initial begin
      {ex_valid, ex_compute, ex_mem, ex_use_imm, dest_we, msw_we} = '0;
      {move_valid, move_write, ex_ra, ex_rb, dest_waddr, ex_imm} = '0;
      {dest_wdata, msw_wdata, move_wdata, move_num} = '0;
   end
   // Released data lines show the inverse so stale values never match.
   task automatic state_write(input logic msw, input logic [4:0] a,
                              input logic [XLEN-1:0] d);
      @(negedge ref_clk);
      dest_we = !msw;
      msw_we = msw;
      dest_waddr = a;
      dest_wdata = d;
      msw_wdata = d;
      @(negedge ref_clk);
      dest_we = 1'b0;
      msw_we = 1'b0;
      dest_wdata = ~d;
      msw_wdata = ~d;
   endtask
   task automatic op_req(input logic c, m, u, input logic [4:0] a, b,
                         input logic [15:0] imm);
      @(negedge ref_clk);
      ex_valid = 1'b1;
      {ex_compute, ex_mem, ex_use_imm} = {c, m, u};
      {ex_ra, ex_rb, ex_imm} = {a, b, imm};
      @(negedge ref_clk);
      ex_valid = 1'b0;
      ex_imm = ~imm;
   endtask
   task automatic special_move(input logic w, input logic [9:0] n,
      input logic [XLEN-1:0] d, output logic [2:0] ans,
      output logic [XLEN-1:0] rd);
      @(negedge ref_clk);
      move_valid = 1'b1;
      move_write = w;
      move_num = n;
      move_wdata = d;
      @(negedge ref_clk);
      ans = {move_done, priv_exc, prog_exc};
      rd = move_rdata;
      move_valid = 1'b0;
      move_wdata = ~d;
   endtask
endmodule

// ==== dv/special_register_access_decode_tb_top.sv ====
// Self-checking bench for the special register file.
// Assumes the checker binds itself; the model drives every input but ref_clk and rst_n.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; \
   if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module special_register_access_decode_tb_top;
   localparam logic [31:0] VID = 32'h0000_5a01; // Arbitrary value.
   localparam logic [31:0] GA = 32'h1111_2222;
   localparam logic [31:0] GB = 32'h8000_0001;
   logic        ref_clk, rst_n, ex_valid, ex_compute, ex_mem, ex_use_imm;
   logic        dest_we, msw_we, move_valid, move_write, op_valid, mem_req;
   logic        move_done, priv_exc, prog_exc, user_mode;
   logic [4:0]  ex_ra, ex_rb, dest_waddr;
   logic [15:0] ex_imm;
   logic [9:0]  move_num;
   logic [31:0] dest_wdata, msw_wdata, move_wdata, op_a, op_b, move_rdata;
   logic [31:0] rd;
   logic [2:0]  ans;
   int          n_errors = 0;
   int          total_checks = 0;
   logic [9:0]  nums [17] = '{10'h001, 10'h008, 10'h009, 10'h012, 10'h013,
      10'h016, 10'h019, 10'h01a, 10'h01b, 10'h110, 10'h111, 10'h112,
      10'h113, 10'h11a, 10'h210, 10'h211, 10'h3f5};
   logic [31:0] msks [17] = '{32'he000007f, '1, '1, '1, '1, '1, '1, '1,
      '1, '1, '1, '1, '1, 32'h8000003f, 32'hfffe1fff, 32'hfffe007b, '1};
   special_reg_file #(.XLEN(32), .VERSION_ID(VID)) dut (.*);
   exec_unit_model #(.XLEN(32)) u_eu (.*);
   //////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] pat(int i);
      return 32'hffff_ffff ^ (32'(i) << 8);
   endfunction
   task automatic mv(input logic w, input logic [9:0] n, input logic [31:0] d);
      u_eu.special_move(w, n, d, ans, rd);
   endtask
   task automatic opx(input logic [2:0] cmu, input logic [4:0] a, b,
      input logic [15:0] imm, input logic [1:0] ev, input logic [31:0] ea, eb);
      u_eu.op_req(cmu[2], cmu[1], cmu[0], a, b, imm);
      `CHK("op_valid mem_req", ev, {op_valid, mem_req})
      if (ev[1]) begin
         `CHK("op_a", ea, op_a)
         `CHK("op_b", eb, op_b)
      end
   endtask
   task automatic t_operands;
      u_eu.state_write(1'b0, 5'd3, GA);
      u_eu.state_write(1'b0, 5'd5, GB);
      opx(3'b100, 5'd3, 5'd5, 16'h0, 2'b10, GA, GB);
      u_eu.state_write(1'b0, 5'd7, 32'h7);
      opx(3'b100, 5'd3, 5'd5, 16'h0, 2'b10, GA, GB);
      opx(3'b101, 5'd5, 5'd3, 16'h8001, 2'b10, GB, 32'hffff_8001);
      opx(3'b010, 5'd3, 5'd7, 16'h0, 2'b11, GA, 32'h7);
      opx(3'b110, 5'd3, 5'd7, 16'h0, 2'b10, GA, 32'h7);
      opx(3'b000, 5'd3, 5'd7, 16'h0, 2'b00, GA, 32'h7);
   endtask
   task automatic t_table;
      for (int i = 0; i < 17; i++) begin
         mv(1'b1, nums[i], pat(i));
         `CHK("write answer", 3'b100, ans)
      end
      for (int i = 0; i < 17; i++) begin
         mv(1'b0, nums[i], '0);
         `CHK("read data", pat(i) & msks[i], rd)
      end
   endtask
   task automatic t_timebase;
      mv(1'b1, 10'h11c, GA);
      `CHK("time base write", 3'b100, ans)
      mv(1'b1, 10'h11d, GB);
      mv(1'b0, 10'h11c, '0);
      `CHK("write-only read", 3'b001, ans)
      mv(1'b1, 10'h11f, '0);
      `CHK("read-only version write", 3'b001, ans)
      mv(1'b1, 10'h10c, '0);
      `CHK("read-only write", 3'b100, ans)
      mv(1'b0, 10'h10c, '0);
      `CHK("time base lower", GA, rd)
      mv(1'b0, 10'h10d, '0);
      `CHK("time base upper", GB, rd)
      mv(1'b0, 10'h11f, '0);
      `CHK("version", VID, rd)
   endtask
   task automatic t_undef;
      mv(1'b1, 10'h010, '1);
      `CHK("msb set write", 3'b001, ans)
      mv(1'b0, 10'h3ff, '0);
      `CHK("msb set read", 3'b001, ans)
      mv(1'b1, 10'h002, '1);
      `CHK("msb clear", {3'b100, 32'h0}, {ans, rd})
      mv(1'b0, 10'h008, '0);
      `CHK("state kept", pat(1), rd)
   endtask
   task automatic t_priv;
      u_eu.state_write(1'b1, 5'd0, 32'h0000_4000);
      `CHK("user mode", 1'b1, user_mode)
      mv(1'b1, 10'h01a, '0);
      `CHK("user restricted write", {3'b010, 32'h0}, {ans, rd})
      mv(1'b0, 10'h013, '0);
      `CHK("user restricted read", {3'b010, 32'h0}, {ans, rd})
      mv(1'b1, 10'h11c, '0);
      `CHK("user time base write", 3'b010, ans)
      mv(1'b0, 10'h10c, '0);
      `CHK("user time base read", {3'b100, GA}, {ans, rd})
      mv(1'b0, 10'h009, '0);
      `CHK("user count read", {3'b100, pat(2)}, {ans, rd})
      mv(1'b0, 10'h010, '0);
      `CHK("undefined first", 3'b001, ans)
      u_eu.state_write(1'b1, 5'd0, 32'h0);
      mv(1'b0, 10'h01a, '0);
      `CHK("write suppressed", pat(7), rd)
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic results;
      if (n_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      rst_n = 1'b0;
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      t_operands;
      t_table;
      t_timebase;
      t_undef;
      t_priv;
      results;
   end
   // The tests need about 150 cycles; this bound cuts a hang short.
   initial begin
      #200000;
      n_errors++;
      results;
   end
endmodule

// ==== dv/spr_access_checker.sv ====
// Checker for the special register file ports.
// Assumes one core clock domain and the bind below.
`timescale 1ns/10ps
module move_access_checker #(
   parameter XLEN = 32
) (
   input wire logic            ref_clk,
   input wire logic            rst_n,
   input wire logic            ex_valid,
   input wire logic            ex_compute,
   input wire logic            ex_mem,
   input wire logic            move_valid,
   input wire logic            move_write,
   input wire logic            op_valid,
   input wire logic            mem_req,
   input wire logic            move_done,
   input wire logic            priv_exc,
   input wire logic            prog_exc,
   input wire logic            user_mode,
   input wire logic [9:0]      move_num,
   input wire logic [XLEN-1:0] move_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_move(n);
      move_valid && move_num == n;
   endsequence
   //////////////////////////////////////////////////////////////////////
   a_op_valid_cause: assert property (
      ex_valid && (ex_compute || ex_mem) |=> op_valid)
      else $error("operand request not answered");
   a_op_valid_idle: assert property (
      !(ex_valid && (ex_compute || ex_mem)) |=> !op_valid)
      else $error("operands flagged without a request");
   a_mem_load_store: assert property (
      ex_valid && ex_mem && !ex_compute |=> mem_req)
      else $error("load or store gave no memory request");
   a_mem_only_ldst: assert property (
      !(ex_valid && ex_mem && !ex_compute) |=> !mem_req)
      else $error("memory request from another class");
   a_move_one_answer: assert property (
      move_valid |=> $onehot({move_done, priv_exc, prog_exc}))
      else $error("move did not get exactly one answer");
   a_move_no_answer: assert property (
      !move_valid |=> !(move_done || priv_exc || prog_exc))
      else $error("answer without a move");
   a_user_suppress: assert property (
      s_move(10'h01a) ##0 user_mode |=> priv_exc && move_rdata == '0)
      else $error("user access to supervisor register allowed");
   a_undef_msb_set: assert property (
      s_move(10'h010) |=> prog_exc)
      else $error("undefined number with msb set not trapped");
   a_undef_noop: assert property (
      s_move(10'h002) |=> move_done && move_rdata == '0)
      else $error("undefined number with msb clear not a no-op");
   a_status_number: assert property (
      s_move(10'h001) ##0 !move_write |=>
         move_done && (move_rdata & ~32'he000007f) == '0)
      else $error("status register reserved bits not zero");
   a_time_base_priv: assert property (
      s_move(10'h11c) ##0 move_write && user_mode |=> priv_exc)
      else $error("user write to time base allowed");
endmodule

bind special_reg_file move_access_checker #(.XLEN(XLEN)) u_chk (.*);

// ==== include/special_reg_consts.vh ====
// Constants for the special register file and its move decode.
// Assumes the including file sits in the core clock domain.
`ifndef SPECIAL_REG_CONSTS_VH
`define SPECIAL_REG_CONSTS_VH

// Special register numbers, as carried in the move instruction operand.
`define NUM_INTEGER_CARRY_OVERFLOW_STATUS 10'h001
`define NUM_BRANCH_RETURN_TARGET          10'h008
`define NUM_LOOP_COUNT                    10'h009
`define NUM_DATA_FAULT_CAUSE              10'h012
`define NUM_DATA_FAULT_ADDRESS            10'h013
`define NUM_COUNTDOWN_TIMER               10'h016
`define NUM_PAGE_TABLE_BASE               10'h019
`define NUM_SAVE_RESTORE_PC               10'h01a
`define NUM_SAVE_RESTORE_STATE            10'h01b
`define NUM_TIME_BASE_LOWER_READ          10'h10c
`define NUM_TIME_BASE_UPPER_READ          10'h10d
`define NUM_SCRATCH_SPECIAL_FIRST         10'h110
`define NUM_EXTERNAL_ACCESS_CONTROL       10'h11a
`define NUM_TIME_BASE_LOWER_WRITE         10'h11c
`define NUM_TIME_BASE_UPPER_WRITE         10'h11d
`define NUM_PROCESSOR_VERSION_ID          10'h11f
`define NUM_BLOCK_TRANSLATION_UPPER       10'h210
`define NUM_BLOCK_TRANSLATION_LOWER       10'h211
`define NUM_DATA_BREAKPOINT_ADDRESS       10'h3f5

// Writable bit masks; cleared bits are reserved and read as zero.
`define MASK_INTEGER_CARRY_OVERFLOW 32'he000007f
`define MASK_EXTERNAL_ACCESS        32'h8000003f
`define MASK_BLOCK_TRANSLATION_UP   32'hfffe1fff
`define MASK_BLOCK_TRANSLATION_LO   32'hfffe007b

// Problem-state (user level) bit of the machine state word.
`define MSW_USER_LEVEL_BIT 14

// Reset values.
`define RESET_WORD32 32'h00000000

`endif
